//--- core/occs_pkg.sv
// Purpose: Constants and carrier types for the OSD per-dot color and attribute selector
// Assumes: One dot clock domain; palette and control bits arrive as plain ports
// Notes: Bitmap layer addresses are byte addresses in the display RAM space

package occs_pkg;

  // ==========================================================
  // Palette
  localparam int unsigned PAL_W = 4;
  localparam int unsigned COLOR_W = 9;
  localparam logic [3:0] PAL_TRANSP = 4'h0;
  localparam logic [3:0] PAL_BLACK = 4'h8;
  localparam logic [8:0] COLOR_BLACK = 9'h000;
  localparam logic [8:0] COLOR_RESET = 9'h000;
  localparam int unsigned PAL_LUMA_BIT = 6;
  localparam int unsigned PAL_REG_W = 10;
  localparam int unsigned PAL_XPARENT_BIT = 9;

  // ==========================================================
  // Movable bitmap layer addressing
  localparam logic [12:0] BMP_FONT1_BASE = 13'h1000;
  localparam logic [12:0] BMP_FONT2_BASE = 13'h1200;
  localparam logic [12:0] BMP_FONT2_LAST = 13'h1327;
  localparam logic [12:0] BMP_PLANE_STEP = 13'h0040;
  localparam logic [12:0] BMP_RIGHT_HALF = 13'h0100;
  localparam int unsigned BMP_LINES = 20;
  localparam int unsigned BMP_DOTS = 32;
  localparam int unsigned BMP_PLANES = 4;

  // ==========================================================
  // Caption underline lines, counted from 1
  localparam logic [4:0] ULINE_FIRST = 5'h17;
  localparam logic [4:0] ULINE_LAST = 5'h18;

  // ==========================================================
  // Display modes
  typedef enum logic [1:0] {
    OCCS_MODE_STD_LRG_PART,
    OCCS_MODE_DOT_COLORED,
    OCCS_MODE_CAPTION
  } occs_mode_t;

  // Per-character display RAM attributes
  typedef struct packed {
    logic [3:0] char_color;
    logic [3:0] substitute_palette;
    logic [3:0] bg_palette;
    logic italic_attr_bit;
    logic flash_attr_bit;
    logic underline_attr_bit;
    logic luma_out_ctrl_bit;
  } occs_char_attr_t;

  // Final per-dot output
  typedef struct packed {
    logic [8:0] color;
    logic visible;
    logic luma_ctrl_out_a;
    logic luma_ctrl_out_b;
  } occs_dot_out_t;

endpackage

//--- core/occs_palette_mem.sv
// Purpose: Sixteen-entry palette store with registered read data
// Assumes: Entries 0 and 8 are stored like any other; the reader ignores or overrides their stored words
// Notes: Entry word holds color, luma bit and transparent-setting bit

`timescale 1ns/10ps
`default_nettype none

module occs_palette_mem (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [9:0] wr_data,
  input wire logic [3:0] rd_idx_a,
  input wire logic [3:0] rd_idx_b,
  output logic [9:0] rd_data_a,
  output logic [9:0] rd_data_b
);

  logic [9:0] mem_reg [16];

  // ==========================================================
  // Storage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 16; i++) begin
        mem_reg[i] <= 10'h000;
      end
    end else if (wr_en) begin
      mem_reg[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_data_a <= 10'h000;
      rd_data_b <= 10'h000;
    end else begin
      rd_data_a <= mem_reg[rd_idx_a];
      rd_data_b <= mem_reg[rd_idx_b];
    end
  end

endmodule

`default_nettype wire

//--- core/occs_select.sv
// Purpose: Per-dot palette code, attribute and luminance-control selection
// Assumes: Dot position, font bits and RAM attributes are presented each dot clock
// Notes: Two-cycle pipeline: code resolve, then palette lookup and output

`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// RULE_01: Bitmap font one: 20 lines, 32 dots, four planes stepping 0x40, bit7 leftmost.
// RULE_02: Bitmap font two uses the same layout from 0x1200, ending at 0x1327.
// RULE_03: Sixteen codes; code 0 transparent and code 8 black, regardless of registers.
// RULE_04: The other fourteen entries each hold any of 512 colors.
// RULE_05: Standard, large, particular modes take code from character color RAM bits.
// RULE_06: Dot-colored mode picks the code per dot from plane font data.
// RULE_07: Dot-colored mode: dot codes 0 or 8 become the character substitute palette.
// RULE_08: Bitmap layer code per dot is formed from its four plane bits.
// RULE_09: Border dots and solid-space on output a always use palette 8.
// RULE_10: Top code 0 shows lower layer; other transparent code shows background only.
// RULE_11: Background palette is taken per character from its RAM setting.
// RULE_12: Background covers cell minus font and border dots; never blended.
// RULE_13: Luma outputs depend on palette bit 6, block bits 0..2 and RAM bit.
// RULE_14: Caption mode applies flash, underline, italic per character from RAM.
// RULE_15: Standard and particular modes use only per-block border, full or shadow.
// RULE_16: Caption underline appears on cell lines 23 and 24.
// RULE_17: Underline uses the character font palette color.
// RULE_18: Flash attribute is the character flash bit, acting in caption mode.
// RULE_19: Italic attribute is the character italic bit, caption mode only.
// RULE_20: Palette code and attributes resolve each dot within one dot period.
module occs_select (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [1:0] mode,
  input wire logic dot_active,
  input wire logic [4:0] cell_line,
  input wire logic font_dot,
  input wire logic [3:0] dot_plane_bits,
  input wire logic border_dot,
  input wire logic [2:0] block_ctrl,
  input wire logic solid_space,
  input wire logic solid_on_a,
  input wire logic flash_phase_off,
  input wire occs_pkg::occs_char_attr_t char_attr,
  input wire logic bmp_active,
  input wire logic bmp_font_sel,
  input wire logic [4:0] bmp_line,
  input wire logic [4:0] bmp_dot,
  input wire logic [1:0] bmp_plane,
  input wire logic [3:0] bmp_plane_bits,
  input wire logic pal_wr,
  input wire logic [3:0] pal_wr_idx,
  input wire logic [9:0] pal_wr_data,
  output logic [12:0] bmp_addr,
  output logic [2:0] bmp_bit,
  output logic italic_req,
  output occs_pkg::occs_dot_out_t dot_out
);

  // ==========================================================
  // Bitmap layer addressing
  logic [12:0] bmp_base;
  logic [12:0] bmp_plane_off;
  logic [12:0] bmp_line_off;
  logic [12:0] bmp_half_off;
  logic [12:0] bmp_addr_next;

  assign bmp_base = bmp_font_sel ? occs_pkg::BMP_FONT2_BASE : occs_pkg::BMP_FONT1_BASE; // [RULE_02]
  assign bmp_plane_off = occs_pkg::BMP_PLANE_STEP * {11'h000, bmp_plane}; // [RULE_01]
  assign bmp_line_off = {7'h00, bmp_line, 1'b0} + {12'h000, bmp_dot[3]}; // [RULE_01]
  assign bmp_half_off = bmp_dot[4] ? occs_pkg::BMP_RIGHT_HALF : 13'h0000; // [RULE_01]
  assign bmp_addr_next = bmp_base + bmp_plane_off + bmp_line_off + bmp_half_off;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bmp_addr <= occs_pkg::BMP_FONT1_BASE;
      bmp_bit <= 3'h7;
    end else begin
      bmp_addr <= bmp_addr_next;
      bmp_bit <= 3'h7 - bmp_dot[2:0]; // [RULE_01]
    end
  end

  // ==========================================================
  // Stage 1: per-dot palette code
  logic is_caption;
  logic is_dot_colored;
  logic is_std;
  logic underline_dot;
  logic flash_hide;
  logic font_shown;
  logic [3:0] dot_code;
  logic [3:0] font_code;
  logic [3:0] char_code;
  logic [3:0] bmp_code;
  logic [3:0] char_code_final;
  logic char_area;
  logic border_shown;
  logic bg_area;

  assign is_caption = mode == occs_pkg::OCCS_MODE_CAPTION;
  assign is_dot_colored = mode == occs_pkg::OCCS_MODE_DOT_COLORED;
  assign is_std = mode == occs_pkg::OCCS_MODE_STD_LRG_PART;
  assign italic_req = is_caption & char_attr.italic_attr_bit; // [RULE_19]
  // Flash only removes font and underline here; blinking the background is a later option
  assign flash_hide = is_caption & char_attr.flash_attr_bit & flash_phase_off; // [RULE_18]
  assign underline_dot = is_caption & char_attr.underline_attr_bit &
    (cell_line == occs_pkg::ULINE_FIRST || cell_line == occs_pkg::ULINE_LAST); // [RULE_16] [RULE_14]
  assign font_shown = (font_dot | underline_dot) & ~flash_hide; // [RULE_14]
  assign dot_code = ((dot_plane_bits == occs_pkg::PAL_TRANSP) || (dot_plane_bits == occs_pkg::PAL_BLACK)) ?
    char_attr.substitute_palette : dot_plane_bits; // [RULE_07]
  // Underline reuses the font code so it always matches the glyph color
  assign font_code = is_dot_colored ? dot_code : char_attr.char_color; // [RULE_05] [RULE_06] [RULE_17]
  // Border only in the standard, large and particular mode, enabled per block
  assign border_shown = is_std & border_dot & (block_ctrl != 3'h0); // [RULE_15]
  assign bg_area = dot_active & ~font_shown & ~border_shown; // [RULE_12]
  assign char_code =
    font_shown ? font_code :
    border_shown ? occs_pkg::PAL_BLACK : // [RULE_09]
    (solid_space & solid_on_a) ? occs_pkg::PAL_BLACK : // [RULE_09]
    char_attr.bg_palette; // [RULE_11]
  assign char_area = dot_active;
  assign char_code_final = char_area ? char_code : occs_pkg::PAL_TRANSP;
  assign bmp_code = bmp_active ? bmp_plane_bits : occs_pkg::PAL_TRANSP; // [RULE_08]

  logic [3:0] top_code_reg;
  logic [3:0] low_code_reg;
  logic bg_area_reg;
  logic font_area_reg;
  logic luma_ram_reg;
  logic [2:0] block_ctrl_reg;
  logic solid_reg;

  // Bitmap layer sits above the character layer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      top_code_reg <= occs_pkg::PAL_TRANSP;
      low_code_reg <= occs_pkg::PAL_TRANSP;
      bg_area_reg <= 1'b0;
      font_area_reg <= 1'b0;
      luma_ram_reg <= 1'b0;
      block_ctrl_reg <= 3'h0;
      solid_reg <= 1'b0;
    end else begin
      top_code_reg <= bmp_code; // [RULE_20]
      low_code_reg <= char_code_final; // [RULE_20]
      bg_area_reg <= bg_area;
      font_area_reg <= dot_active & ~bg_area;
      luma_ram_reg <= char_attr.luma_out_ctrl_bit;
      block_ctrl_reg <= block_ctrl;
      solid_reg <= solid_space;
    end
  end

  // ==========================================================
  // Stage 2: palette lookup
  logic [9:0] top_word;
  logic [9:0] low_word;

  occs_palette_mem u_pal (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wr_en(pal_wr),
    .wr_idx(pal_wr_idx),
    .wr_data(pal_wr_data),
    .rd_idx_a(bmp_code),
    .rd_idx_b(char_code_final),
    .rd_data_a(top_word),
    .rd_data_b(low_word)
  ); // [RULE_04]

  logic top_is_zero;
  logic top_is_black;
  logic low_is_zero;
  logic low_is_black;
  logic top_xparent;
  logic low_xparent;
  logic [8:0] top_color;
  logic [8:0] low_color;
  logic [8:0] color_next;
  logic visible_next;
  logic top_luma;
  logic low_luma;
  logic luma_a_next;
  logic luma_b_next;

  assign top_is_zero = top_code_reg == occs_pkg::PAL_TRANSP;
  assign top_is_black = top_code_reg == occs_pkg::PAL_BLACK;
  assign low_is_zero = low_code_reg == occs_pkg::PAL_TRANSP;
  assign low_is_black = low_code_reg == occs_pkg::PAL_BLACK;
  assign top_xparent = ~top_is_black & top_word[occs_pkg::PAL_XPARENT_BIT];
  assign low_xparent = ~low_is_black & low_word[occs_pkg::PAL_XPARENT_BIT];
  assign top_color = top_is_black ? occs_pkg::COLOR_BLACK : top_word[8:0]; // [RULE_03]
  assign low_color = low_is_black ? occs_pkg::COLOR_BLACK : low_word[8:0]; // [RULE_03]
  assign top_luma = ~top_is_zero & (top_is_black | top_word[occs_pkg::PAL_LUMA_BIT]);
  assign low_luma = ~low_is_zero & (low_is_black | low_word[occs_pkg::PAL_LUMA_BIT]);

  // Code 0 falls through; a marked-transparent code blocks the layer below
  always_comb begin
    color_next = occs_pkg::COLOR_RESET;
    visible_next = 1'b0;
    if (!top_is_zero) begin
      if (!top_xparent) begin
        color_next = top_color;
        visible_next = 1'b1;
      end
    end else if (!low_is_zero && !low_xparent) begin
      color_next = low_color;
      visible_next = 1'b1;
    end
  end // [RULE_10]

  // Output a follows a non-zero bitmap code's luma bit, else the character code's when its block enables it, or solid space
  assign luma_a_next = top_is_zero ?
    (low_luma & (block_ctrl_reg != 3'h0) | solid_reg) : top_luma; // [RULE_13]
  assign luma_b_next = top_is_zero ?
    (luma_ram_reg & (bg_area_reg | font_area_reg)) : 1'b0; // [RULE_13]

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dot_out <= '0;
    end else begin
      dot_out.color <= color_next;
      dot_out.visible <= visible_next;
      dot_out.luma_ctrl_out_a <= luma_a_next;
      dot_out.luma_ctrl_out_b <= luma_b_next;
    end
  end

  // ==========================================================
  // Checks
  property p_black_fixed;
    @(posedge sys_clk) disable iff (sys_rst)
      (bmp_code == occs_pkg::PAL_BLACK) |=> ##1 (dot_out.color == occs_pkg::COLOR_BLACK && dot_out.visible);
  endproperty
  a_black_fixed: assert property (p_black_fixed) else $error("palette 8 not black"); // [RULE_03]

  property p_transp_fall;
    @(posedge sys_clk) disable iff (sys_rst)
      (bmp_code == occs_pkg::PAL_TRANSP && char_code_final == occs_pkg::PAL_TRANSP) |=> ##1 !dot_out.visible;
  endproperty
  a_transp_fall: assert property (p_transp_fall) else $error("code 0 visible"); // [RULE_10]

  property p_subst;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_dot_colored && dot_active && font_dot && dot_plane_bits == occs_pkg::PAL_BLACK)
        |-> char_code_final == char_attr.substitute_palette;
  endproperty
  a_subst: assert property (p_subst) else $error("substitute palette missed"); // [RULE_07]

  property p_std_code;
    @(posedge sys_clk) disable iff (sys_rst)
      (!is_dot_colored && dot_active && font_dot && !flash_hide) |-> char_code_final == char_attr.char_color;
  endproperty
  a_std_code: assert property (p_std_code) else $error("character color wrong"); // [RULE_05]

  property p_border_black;
    @(posedge sys_clk) disable iff (sys_rst)
      (dot_active && border_shown && !font_shown) |-> char_code_final == occs_pkg::PAL_BLACK;
  endproperty
  a_border_black: assert property (p_border_black) else $error("border not palette 8"); // [RULE_09]

  property p_uline;
    @(posedge sys_clk) disable iff (sys_rst)
      (!is_caption || cell_line < occs_pkg::ULINE_FIRST) |-> !underline_dot;
  endproperty
  a_uline: assert property (p_uline) else $error("underline out of place"); // [RULE_16]

  property p_bg;
    @(posedge sys_clk) disable iff (sys_rst)
      (dot_active && !font_dot && !border_dot && !(solid_space && solid_on_a) && !underline_dot)
        |-> char_code_final == char_attr.bg_palette;
  endproperty
  a_bg: assert property (p_bg) else $error("background palette wrong"); // [RULE_11]

  property p_bmp_addr;
    @(posedge sys_clk) disable iff (sys_rst)
      (bmp_font_sel && bmp_line == 5'h13 && bmp_dot == 5'h1f && bmp_plane == 2'h0)
        |=> bmp_addr == occs_pkg::BMP_FONT2_LAST;
  endproperty
  a_bmp_addr: assert property (p_bmp_addr) else $error("bitmap last address wrong"); // [RULE_02]

  property p_bmp_first;
    @(posedge sys_clk) disable iff (sys_rst)
      (!bmp_font_sel && bmp_line == 5'h00 && bmp_dot == 5'h00 && bmp_plane == 2'h0)
        |=> bmp_addr == occs_pkg::BMP_FONT1_BASE;
  endproperty
  a_bmp_first: assert property (p_bmp_first) else $error("bitmap first address wrong"); // [RULE_01]

  property p_bmp_bit;
    @(posedge sys_clk) disable iff (sys_rst)
      (bmp_dot[2:0] == 3'h0) |=> bmp_bit == 3'h7;
  endproperty
  a_bmp_bit: assert property (p_bmp_bit) else $error("leftmost dot not bit 7"); // [RULE_01]

  property p_dot_code;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_dot_colored && dot_active && font_dot && dot_plane_bits != occs_pkg::PAL_TRANSP &&
        dot_plane_bits != occs_pkg::PAL_BLACK) |-> char_code_final == dot_plane_bits;
  endproperty
  a_dot_code: assert property (p_dot_code) else $error("dot code not taken from planes"); // [RULE_06]

  property p_subst_zero;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_dot_colored && dot_active && font_dot && dot_plane_bits == occs_pkg::PAL_TRANSP)
        |-> char_code_final == char_attr.substitute_palette;
  endproperty
  a_subst_zero: assert property (p_subst_zero) else $error("code 0 not substituted"); // [RULE_07]

  property p_top_xparent;
    @(posedge sys_clk) disable iff (sys_rst)
      (!top_is_zero && top_xparent) |=> !dot_out.visible;
  endproperty
  a_top_xparent: assert property (p_top_xparent) else $error("marked transparent code not keyed"); // [RULE_10]

  property p_low_black;
    @(posedge sys_clk) disable iff (sys_rst)
      (top_is_zero && low_is_black) |=> (dot_out.color == occs_pkg::COLOR_BLACK && dot_out.visible);
  endproperty
  a_low_black: assert property (p_low_black) else $error("character palette 8 not black"); // [RULE_03]

  property p_uline_color;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_caption && dot_active && underline_dot && !flash_hide)
        |-> char_code_final == char_attr.char_color;
  endproperty
  a_uline_color: assert property (p_uline_color) else $error("underline color wrong"); // [RULE_17]

  property p_flash_hide;
    @(posedge sys_clk) disable iff (sys_rst)
      (is_caption && dot_active && flash_hide && !(solid_space && solid_on_a))
        |-> char_code_final == char_attr.bg_palette;
  endproperty
  a_flash_hide: assert property (p_flash_hide) else $error("flash off phase shows font"); // [RULE_18]

  property p_no_border;
    @(posedge sys_clk) disable iff (sys_rst)
      (!is_std && dot_active && border_dot && !font_shown && !(solid_space && solid_on_a))
        |-> char_code_final == char_attr.bg_palette;
  endproperty
  a_no_border: assert property (p_no_border) else $error("border outside its modes"); // [RULE_15]

  property p_solid_black;
    @(posedge sys_clk) disable iff (sys_rst)
      (dot_active && !font_shown && !border_shown && solid_space && solid_on_a)
        |-> char_code_final == occs_pkg::PAL_BLACK;
  endproperty
  a_solid_black: assert property (p_solid_black) else $error("solid space not palette 8"); // [RULE_09]

  property p_luma_b;
    @(posedge sys_clk) disable iff (sys_rst)
      (!luma_ram_reg) |=> !dot_out.luma_ctrl_out_b;
  endproperty
  a_luma_b: assert property (p_luma_b) else $error("output b without its RAM bit"); // [RULE_13]

endmodule

`default_nettype wire

//--- testbench/occs_video_rx.sv
// Purpose: Video mixing path model that receives the selected dot stream
// Assumes: The mixer latches color, key and luma controls on every dot clock
// Notes: Pure sink; the mixer never pushes back on the selector

`timescale 1ns/10ps
`default_nettype none

module occs_video_rx (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire occs_pkg::occs_dot_out_t dot_in,
  output occs_pkg::occs_dot_out_t mix_dot
);
  // ==========================================================
  // Mixer input latch
  // A reset mixer keys nothing, so a stale dot never reaches the screen
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mix_dot <= '0;
    end else begin
      mix_dot <= dot_in;
    end
  end
endmodule

`default_nettype wire

//--- testbench/occs_select_tb.sv
// Purpose: Self-checking bench for the per-dot color and attribute selector
// Assumes: Dot inputs are held steady until the mixer shows the result
// Notes: Dot results are read at the mixer model, three edges after sampling

`timescale 1ns/10ps
`default_nettype none

module occs_select_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] mode;
  logic dot_active, font_dot, border_dot, solid_space, solid_on_a, flash_phase_off;
  logic bmp_active, bmp_font_sel, pal_wr;
  logic [4:0] cell_line, bmp_line, bmp_dot;
  logic [3:0] dot_plane_bits, bmp_plane_bits, pal_wr_idx;
  logic [2:0] block_ctrl, bmp_bit;
  logic [1:0] bmp_plane;
  logic [9:0] pal_wr_data;
  logic [12:0] bmp_addr;
  logic italic_req;
  occs_pkg::occs_char_attr_t char_attr;
  occs_pkg::occs_dot_out_t dot_out, mix;
  int fail_count = 0;
  int comparisons = 0;

  always #2 sys_clk = ~sys_clk;

  occs_select dut (.sys_clk, .sys_rst, .mode, .dot_active, .cell_line, .font_dot, .dot_plane_bits,
    .border_dot, .block_ctrl, .solid_space, .solid_on_a, .flash_phase_off, .char_attr, .bmp_active,
    .bmp_font_sel, .bmp_line, .bmp_dot, .bmp_plane, .bmp_plane_bits, .pal_wr, .pal_wr_idx,
    .pal_wr_data, .bmp_addr, .bmp_bit, .italic_req, .dot_out);

  occs_video_rx mixer (.sys_clk(sys_clk), .sys_rst(sys_rst), .dot_in(dot_out), .mix_dot(mix));

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic pal_write(input logic [3:0] idx, input logic [9:0] data);
    @(posedge sys_clk);
    pal_wr <= 1'b1;
    pal_wr_idx <= idx;
    pal_wr_data <= data;
  endtask

  // Character dot with substitute palette 7 and background palette 2
  task automatic put(input logic [1:0] m, input logic fd, input logic [3:0] planes, input logic [3:0] cc);
    @(posedge sys_clk);
    pal_wr <= 1'b0;
    mode <= m;
    dot_active <= 1'b1;
    font_dot <= fd;
    dot_plane_bits <= planes;
    char_attr <= '{char_color: cc, substitute_palette: 4'h7, bg_palette: 4'h2, default: 1'b0};
    border_dot <= 1'b0;
    solid_space <= 1'b0;
    solid_on_a <= 1'b0;
    block_ctrl <= 3'h0;
    flash_phase_off <= 1'b0;
    bmp_active <= 1'b0;
    cell_line <= 5'h01;
  endtask

  task automatic settle();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  task automatic expect_dot(input logic [8:0] color, input logic vis);
    settle();
    check("color", 16'(mix.color), 16'(color));
    check("visible", 16'(mix.visible), 16'(vis));
    @(posedge sys_clk);
  endtask

  task automatic bmp_case(input logic f, input logic [1:0] p, input logic [4:0] l, input logic [4:0] d,
                          input logic [12:0] a, input logic [2:0] b);
    @(posedge sys_clk);
    bmp_font_sel <= f;
    bmp_plane <= p;
    bmp_line <= l;
    bmp_dot <= d;
    repeat (2) @(posedge sys_clk);
    #1;
    check("bmp_addr", 16'(bmp_addr), 16'(a));
    check("bmp_bit", 16'(bmp_bit), 16'(b));
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_bmp_addr();
    bmp_case(1'b0, 2'h0, 5'h00, 5'h00, 13'h1000, 3'h7);
    bmp_case(1'b0, 2'h3, 5'h00, 5'h10, 13'h11c0, 3'h7);
    bmp_case(1'b0, 2'h1, 5'h01, 5'h09, 13'h1043, 3'h6);
    bmp_case(1'b1, 2'h0, 5'h13, 5'h1f, occs_pkg::BMP_FONT2_LAST, 3'h0);
    $display("test bmp_addr done");
  endtask

  task automatic t_char_codes();
    put(occs_pkg::OCCS_MODE_STD_LRG_PART, 1'b1, 4'h0, 4'h3);
    expect_dot(9'h1a5, 1'b1);
    put(occs_pkg::OCCS_MODE_STD_LRG_PART, 1'b1, 4'h0, 4'h8);
    expect_dot(occs_pkg::COLOR_BLACK, 1'b1);
    put(occs_pkg::OCCS_MODE_STD_LRG_PART, 1'b1, 4'h0, 4'h0);
    settle();
    check("visible", 16'(mix.visible), 16'h0000);
    $display("test char_codes done");
  endtask

  task automatic t_dot_colored();
    put(occs_pkg::OCCS_MODE_DOT_COLORED, 1'b1, 4'h5, 4'h3);
    expect_dot(9'h0f3, 1'b1);
    put(occs_pkg::OCCS_MODE_DOT_COLORED, 1'b1, 4'h0, 4'h3);
    expect_dot(9'h07c, 1'b1);
    put(occs_pkg::OCCS_MODE_DOT_COLORED, 1'b1, 4'h8, 4'h3);
    expect_dot(9'h07c, 1'b1);
    $display("test dot_colored done");
  endtask

  task automatic t_bitmap();
    put(occs_pkg::OCCS_MODE_STD_LRG_PART, 1'b1, 4'h0, 4'h3);
    bmp_active <= 1'b1;
    bmp_plane_bits <= 4'h5;
    expect_dot(9'h0f3, 1'b1);
    bmp_plane_bits <= 4'h0;
    expect_dot(9'h1a5, 1'b1);
    bmp_plane_bits <= 4'h8;
    expect_dot(occs_pkg::COLOR_BLACK, 1'b1);
    bmp_plane_bits <= 4'h6;
    settle();
    check("visible", 16'(mix.visible), 16'h0000);
    $display("test bitmap done");
  endtask

  task automatic t_back_border();
    put(occs_pkg::OCCS_MODE_STD_LRG_PART, 1'b0, 4'h0, 4'h3);
    expect_dot(9'h10a, 1'b1);
    border_dot <= 1'b1;
    block_ctrl <= 3'h1;
    expect_dot(occs_pkg::COLOR_BLACK, 1'b1);
    put(occs_pkg::OCCS_MODE_CAPTION, 1'b0, 4'h0, 4'h3);
    solid_space <= 1'b1;
    solid_on_a <= 1'b1;
    settle();
    check("color", 16'(mix.color), 16'(occs_pkg::COLOR_BLACK));
    check("visible", 16'(mix.visible), 16'h0001);
    check("luma_a", 16'(mix.luma_ctrl_out_a), 16'h0001);
    $display("test back_border done");
  endtask

  task automatic t_caption();
    put(occs_pkg::OCCS_MODE_CAPTION, 1'b0, 4'h0, 4'h3);
    char_attr.underline_attr_bit <= 1'b1;
    cell_line <= occs_pkg::ULINE_FIRST;
    expect_dot(9'h1a5, 1'b1);
    cell_line <= occs_pkg::ULINE_LAST;
    expect_dot(9'h1a5, 1'b1);
    cell_line <= 5'h16;
    expect_dot(9'h10a, 1'b1);
    mode <= occs_pkg::OCCS_MODE_STD_LRG_PART;
    cell_line <= 5'h17;
    expect_dot(9'h10a, 1'b1);
    put(occs_pkg::OCCS_MODE_CAPTION, 1'b1, 4'h0, 4'h3);
    char_attr.flash_attr_bit <= 1'b1;
    char_attr.italic_attr_bit <= 1'b1;
    flash_phase_off <= 1'b1;
    border_dot <= 1'b1;
    block_ctrl <= 3'h1;
    expect_dot(9'h10a, 1'b1);
    check("italic_req", 16'(italic_req), 16'h0001);
    mode <= occs_pkg::OCCS_MODE_STD_LRG_PART;
    settle();
    check("italic_req", 16'(italic_req), 16'h0000);
    $display("test caption done");
  endtask

  task automatic t_luma();
    put(occs_pkg::OCCS_MODE_STD_LRG_PART, 1'b1, 4'h0, 4'h4);
    block_ctrl <= 3'h1;
    settle();
    check("luma_a", 16'(mix.luma_ctrl_out_a), 16'h0001);
    @(posedge sys_clk);
    block_ctrl <= 3'h0;
    char_attr.luma_out_ctrl_bit <= 1'b1;
    settle();
    check("luma_a", 16'(mix.luma_ctrl_out_a), 16'h0000);
    check("luma_b", 16'(mix.luma_ctrl_out_b), 16'h0001);
    $display("test luma done");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    put(2'h0, 1'b0, 4'h0, 4'h0);
    dot_active <= 1'b0;
    bmp_font_sel <= 1'b0;
    bmp_line <= 5'h00;
    bmp_dot <= 5'h00;
    bmp_plane <= 2'h0;
    bmp_plane_bits <= 4'h0;
    pal_wr_idx <= 4'h0;
    pal_wr_data <= 10'h000;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    pal_write(4'h3, 10'h1a5);
    pal_write(4'h8, 10'h1ff);
    pal_write(4'h0, 10'h0ff);
    pal_write(4'h5, 10'h0f3);
    pal_write(4'h4, 10'h040);
    pal_write(4'h6, 10'h233);
    pal_write(4'h2, 10'h10a);
    pal_write(4'h7, 10'h07c);
    @(posedge sys_clk);
    pal_wr <= 1'b0;
    t_bmp_addr();
    t_char_codes();
    t_dot_colored();
    t_bitmap();
    t_back_border();
    t_caption();
    t_luma();
    give_verdict();
  end

  // Whole run needs well under a thousand dot clocks
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    give_verdict();
  end
endmodule

`default_nettype wire
